// >>> mpt_chan.sv
// one pwm output stage: set and clear events into a registered level
module mpt_chan
  import mpt_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control and events
  input  wire logic enable,
  input  wire logic set_ev,
  input  wire logic clr_ev,
  // output
  output logic      pwm_out
);
  logic next_out;  // next output level

  // clear beats set so a zero width stays low all cycle
  always_comb begin
    next_out = pwm_out;
    if (!enable) begin
      next_out = 1'b0;
    end else if (clr_ev) begin
      next_out = 1'b0;  // [R04] [R06]
    end else if (set_ev) begin
      next_out = 1'b1;  // [R02] [R06]
    end
  end

  // output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= next_out;
    end
  end
endmodule

// >>> mpt_pkg.sv
// package: register map, field positions and reset values of the pwm timer
package mpt_pkg;
  // sizes
  localparam int          NUM_MATCH = 7;           // match registers, index 0 sets the period
  localparam int          NUM_PWM   = 6;           // pwm outputs 1..6
  localparam int          NUM_CAP   = 2;           // capture inputs usable as count source
  localparam int          ADDR_W    = 8;           // apb byte address width
  // register byte offsets
  localparam logic [7:0]  OFF_STATUS    = 8'h00;   // sticky match events, write one to clear
  localparam logic [7:0]  OFF_MASK      = 8'h04;   // interrupt mask, same layout
  localparam logic [7:0]  OFF_CTRL      = 8'h08;   // run, hold in reset, pwm mode
  localparam logic [7:0]  OFF_COUNT     = 8'h0C;   // timer count
  localparam logic [7:0]  OFF_PRESCALE  = 8'h10;   // prescale terminal value
  localparam logic [7:0]  OFF_PRECOUNT  = 8'h14;   // prescale counter, read only
  localparam logic [7:0]  OFF_MATCHCTL  = 8'h18;   // three action bits per match
  localparam logic [7:0]  OFF_MATCH0    = 8'h1C;   // period_match_register, then matches 1..6
  localparam logic [7:0]  OFF_CNTCTL    = 8'h38;   // count source mode and capture select
  localparam logic [7:0]  OFF_PWMCTL    = 8'h3C;   // double edge selects and output enables
  localparam logic [7:0]  OFF_RELEASE   = 8'h40;   // release of new match values
  localparam logic [7:0]  MATCH_STRIDE  = 8'h04;   // spacing of match words
  // control register fields
  localparam int          CTL_RUN   = 0;           // counting enabled
  localparam int          CTL_HOLD  = 1;           // count and prescaler held at zero
  localparam int          CTL_PWM   = 2;           // pwm mode
  localparam int          CTL_W     = 3;
  // match control fields, per match k at k*MCR_W
  localparam int          MCR_INT   = 0;           // raise status bit on match
  localparam int          MCR_RST   = 1;           // reset count on match
  localparam int          MCR_STOP  = 2;           // stop counting on match
  localparam int          MCR_W     = 3;
  // count control fields
  localparam int          CCR_MODE  = 0;           // two bits, see mode enum
  localparam int          CCR_SEL   = 2;           // capture input select
  localparam int          CCR_W     = 3;
  // pwm control fields
  localparam int          PCR_DBL   = 2;           // bits 2..6: output n is double edge
  localparam int          PCR_ENA   = 9;           // bits 9..14: output n enable at 8+n
  localparam int          PCR_W     = 15;
  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  // count source
  typedef enum logic [1:0] {
    MPT_SRC_CLK,                                   // every pclk
    MPT_SRC_RISE,                                  // rising edges of capture input
    MPT_SRC_FALL,                                  // falling edges
    MPT_SRC_BOTH                                   // both edges
  } mpt_mode_e;
endpackage

// >>> mpt_pwm_timer.sv
// multi channel pwm timer with apb register slave and match interrupt
// Notes on behaviour
// R01: period match resets count, sets shared period
// R02: single edge outputs rise at period match
// R03: single edge falls at its own match
// R04: zero edge value keeps output constantly low
// R05: double edge uses rise and fall matches
// R06: rise first positive pulse, else negative
// R07: seven matches, six single or three double
// R08: per match continue, stop or reset, interrupt
// R09: released match values apply at period match
// R10: without pwm mode, plain timer behaviour
// R11: 32-bit count behind 32-bit prescaler
// R12: count source pclk or capture input edges
// R13: period and width any whole tick count
// R14: prescaler terminal value advances count, restarts
module mpt_pwm_timer
  import mpt_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // count source
  input  wire logic [NUM_CAP-1:0] cap_in,
  // outputs
  output logic      [NUM_PWM:1]  pwm_out,
  output logic                   irq
);
  // register state
  logic [NUM_MATCH-1:0] status;          // sticky match events
  logic [NUM_MATCH-1:0] mask;            // interrupt mask
  logic [CTL_W-1:0]     ctrl;            // run, hold, pwm mode
  logic [31:0]          count;           // timer count
  logic [31:0]          prescale;        // prescale terminal value
  logic [31:0]          precount;        // prescale counter
  logic [NUM_MATCH*MCR_W-1:0] matchctl;  // match actions
  logic [31:0]          match [NUM_MATCH];   // software match values
  logic [31:0]          shadow [NUM_MATCH];  // values used by compare
  logic [CCR_W-1:0]     cntctl;          // count source
  logic [PCR_W-1:0]     pwmctl;          // output types and enables
  logic [NUM_MATCH-1:0] release_q;       // pending release per match
  logic [NUM_CAP-1:0]   cap_prev;        // capture inputs one cycle ago
  // next values
  logic [NUM_MATCH-1:0] next_status;
  logic [NUM_MATCH-1:0] next_mask;
  logic [CTL_W-1:0]     next_ctrl;
  logic [31:0]          next_count;
  logic [31:0]          next_prescale;
  logic [31:0]          next_precount;
  logic [NUM_MATCH*MCR_W-1:0] next_matchctl;
  logic [31:0]          next_match [NUM_MATCH];
  logic [31:0]          next_shadow [NUM_MATCH];
  logic [CCR_W-1:0]     next_cntctl;
  logic [PCR_W-1:0]     next_pwmctl;
  logic [NUM_MATCH-1:0] next_release;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;
  logic                 next_irq;
  // decoded strobes and timer events
  logic                 setup;           // apb setup cycle
  logic                 wr;              // write taken this edge
  logic [NUM_MATCH-1:0] hit;             // match events on this tick
  logic                 src_ev;          // count source event
  logic                 tick;            // count advances
  logic                 cap_now;         // selected capture level
  logic                 cap_old;         // selected capture level, previous
  logic                 pwm_mode;        // pwm mode active
  mpt_mode_e            mode;            // count source mode
  logic [31:0]          rd_val;          // read mux
  logic                 rd_bad;          // unmapped address
  logic [NUM_PWM:1]     set_ev;          // per output set
  logic [NUM_PWM:1]     clr_ev;          // per output clear

  assign setup    = psel && !penable;
  assign wr       = psel && penable && pready && pwrite;
  assign pwm_mode = ctrl[CTL_PWM];
  assign mode     = mpt_mode_e'(cntctl[CCR_MODE +: 2]);
  assign cap_now  = cap_in[cntctl[CCR_SEL]];
  assign cap_old  = cap_prev[cntctl[CCR_SEL]];

  // count source and prescaler terminal detect
  always_comb begin
    case (mode)  // [R12]
      MPT_SRC_CLK:  src_ev = 1'b1;
      MPT_SRC_RISE: src_ev = cap_now && !cap_old;
      MPT_SRC_FALL: src_ev = !cap_now && cap_old;
      MPT_SRC_BOTH: src_ev = cap_now != cap_old;
      default:      src_ev = 1'b0;
    endcase
    tick = ctrl[CTL_RUN] && !ctrl[CTL_HOLD] && src_ev && (precount == prescale);  // [R14]
  end

  // full width compare of every match on a tick
  always_comb begin
    for (int k = 0; k < NUM_MATCH; k++) begin
      hit[k] = tick && (count == shadow[k]);  // [R11] [R13]
    end
  end

  // pwm output events
  genvar n;
  generate
    for (n = 1; n <= NUM_PWM; n++) begin : g_out
      logic dbl;  // output uses two matches
      if (n == 1) begin : g_single
        assign dbl = 1'b0;
      end else begin : g_dual
        assign dbl = pwmctl[PCR_DBL + n - 2];
      end
      // single: rise at period unless edge is zero; double: rise at match n-1
      assign set_ev[n] = dbl ? hit[n-1] : (hit[0] && (shadow[n] != RST_WORD));  // [R02] [R04] [R05]
      assign clr_ev[n] = hit[n];  // [R03] [R05]
      mpt_chan u_chan (  // [R07]
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (pwm_mode && pwmctl[PCR_ENA + n - 1]),
        .set_ev  (set_ev[n]),
        .clr_ev  (clr_ev[n]),
        .pwm_out (pwm_out[n])
      );
    end
  endgenerate

  // read mux with unmapped detection
  always_comb begin
    rd_val = RST_WORD;
    rd_bad = 1'b0;
    case (paddr)
      OFF_STATUS:   rd_val = {25'h0, status};
      OFF_MASK:     rd_val = {25'h0, mask};
      OFF_CTRL:     rd_val = {29'h0, ctrl};
      OFF_COUNT:    rd_val = count;
      OFF_PRESCALE: rd_val = prescale;
      OFF_PRECOUNT: rd_val = precount;
      OFF_MATCHCTL: rd_val = {11'h0, matchctl};
      OFF_CNTCTL:   rd_val = {29'h0, cntctl};
      OFF_PWMCTL:   rd_val = {17'h0, pwmctl};
      OFF_RELEASE:  rd_val = {25'h0, release_q};
      default: begin
        rd_bad = 1'b1;
        for (int k = 0; k < NUM_MATCH; k++) begin
          if (paddr == 8'(OFF_MATCH0 + 8'(k) * MATCH_STRIDE)) begin
            rd_val = match[k];
            rd_bad = 1'b0;
          end
        end
      end
    endcase
  end

  // register writes, counting, match actions and shadow loads
  always_comb begin
    next_mask     = mask;
    next_ctrl     = ctrl;
    next_prescale = prescale;
    next_matchctl = matchctl;
    next_cntctl   = cntctl;
    next_pwmctl   = pwmctl;
    next_release  = release_q;
    next_count    = count;
    next_precount = precount;
    next_status   = status;
    for (int k = 0; k < NUM_MATCH; k++) begin
      next_match[k]  = match[k];
      next_shadow[k] = shadow[k];
    end
    // prescaler and count
    if (ctrl[CTL_HOLD]) begin
      next_count    = RST_WORD;
      next_precount = RST_WORD;
    end else if (tick) begin
      next_precount = RST_WORD;  // [R14]
      next_count    = count + 32'h1;  // [R11]
    end else if (ctrl[CTL_RUN] && src_ev) begin
      next_precount = precount + 32'h1;  // [R14]
    end
    // match actions, pwm mode always restarts at the period match
    for (int k = 0; k < NUM_MATCH; k++) begin
      if (hit[k] && matchctl[k*MCR_W + MCR_RST]) begin
        next_count = RST_WORD;  // [R08] [R10]
      end
      if (hit[k] && matchctl[k*MCR_W + MCR_STOP]) begin
        next_ctrl[CTL_RUN] = 1'b0;  // [R08]
      end
    end
    if (hit[0] && pwm_mode) begin
      next_count = RST_WORD;  // [R01]
    end
    // software writes
    if (wr) begin
      case (paddr)
        OFF_STATUS:   next_status  = status & ~pwdata[NUM_MATCH-1:0];
        OFF_MASK:     next_mask    = pwdata[NUM_MATCH-1:0];
        OFF_CTRL:     next_ctrl    = pwdata[CTL_W-1:0];
        OFF_COUNT:    next_count   = pwdata;
        OFF_PRESCALE: next_prescale = pwdata;
        OFF_MATCHCTL: next_matchctl = pwdata[NUM_MATCH*MCR_W-1:0];
        OFF_CNTCTL:   next_cntctl  = pwdata[CCR_W-1:0];
        OFF_PWMCTL:   next_pwmctl  = pwdata[PCR_W-1:0];
        default: begin
          for (int k = 0; k < NUM_MATCH; k++) begin
            if (paddr == 8'(OFF_MATCH0 + 8'(k) * MATCH_STRIDE)) begin
              next_match[k] = pwdata;
            end
          end
        end
      endcase
    end
    // interrupt events win over a clear in the same cycle
    for (int k = 0; k < NUM_MATCH; k++) begin
      if (hit[k] && matchctl[k*MCR_W + MCR_INT]) begin
        next_status[k] = 1'b1;  // [R08]
      end
    end
    // shadow loading
    for (int k = 0; k < NUM_MATCH; k++) begin
      if (!pwm_mode) begin
        next_shadow[k] = match[k];  // [R10]
      end else if (hit[0] && release_q[k]) begin
        next_shadow[k]  = match[k];  // [R09]
        next_release[k] = 1'b0;  // [R09]
      end
    end
    // release bits written by software, a new set beats the hardware clear
    if (wr && paddr == OFF_RELEASE) begin
      next_release = next_release | pwdata[NUM_MATCH-1:0];  // [R09]
    end
  end

  // register and timer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status    <= '0;
      mask      <= '0;
      ctrl      <= '0;
      count     <= RST_WORD;
      prescale  <= RST_WORD;
      precount  <= RST_WORD;
      matchctl  <= '0;
      cntctl    <= '0;
      pwmctl    <= '0;
      release_q <= '0;
      cap_prev  <= '0;
      for (int k = 0; k < NUM_MATCH; k++) begin
        match[k]  <= RST_WORD;
        shadow[k] <= RST_WORD;
      end
    end else begin
      status    <= next_status;
      mask      <= next_mask;
      ctrl      <= next_ctrl;
      count     <= next_count;
      prescale  <= next_prescale;
      precount  <= next_precount;
      matchctl  <= next_matchctl;
      cntctl    <= next_cntctl;
      pwmctl    <= next_pwmctl;
      release_q <= next_release;
      cap_prev  <= cap_in;
      for (int k = 0; k < NUM_MATCH; k++) begin
        match[k]  <= next_match[k];
        shadow[k] <= next_shadow[k];
      end
    end
  end

  // bus answer: data caught in setup, ready in the access cycle
  always_comb begin
    next_pready  = setup;
    next_pslverr = setup && rd_bad;
    next_prdata  = prdata;
    if (setup && !pwrite) begin
      next_prdata = rd_val;
    end
    next_irq = |(next_status & mask);
  end

  // bus answer and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      irq     <= next_irq;
    end
  end
endmodule

// >>> mpt_pwm_timer_sva.sv
// checker: apb timing, refusals and output gating of the pwm timer
module mpt_pwm_chk
  import mpt_pkg::*;
(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave side
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [31:0]        prdata,
  input  wire logic               pready,
  input  wire logic               pslverr,
  // count source and outputs
  input  wire logic [NUM_CAP-1:0] cap_in,
  input  wire logic [NUM_PWM:1]   pwm_out,
  input  wire logic               irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       wr_done;     // apb write completes at this edge
  logic [6:0] mask_q;      // mask as software last wrote it
  logic       pwm_q;       // pwm mode bit as last written
  logic [6:0] next_mask_q; // next mask copy
  logic       next_pwm_q;  // next mode copy
  assign wr_done = psel && penable && pready && pwrite;
  // follow writes to mask and control
  always_comb begin
    next_mask_q = mask_q;
    next_pwm_q  = pwm_q;
    if (wr_done && paddr == OFF_MASK) next_mask_q = pwdata[6:0];
    if (wr_done && paddr == OFF_CTRL) next_pwm_q = pwdata[CTL_PWM];
  end
  // register the copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 7'h00;
      pwm_q  <= 1'b0;
    end else begin
      mask_q <= next_mask_q;
      pwm_q  <= next_pwm_q;
    end
  end
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_unmapped: assert property (psel && !penable && paddr > 8'h40 |=> pslverr)
    else $error("unmapped access not refused");
  chk_ok_mapped: assert property (psel && !penable && paddr <= 8'h40 && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("mapped access refused");
  chk_rd_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  chk_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without read");
  chk_irq_masked: assert property (mask_q == 7'h00 && $past(mask_q) == 7'h00 |-> !irq)
    else $error("irq high while fully masked");
  chk_pwm_off_low: assert property (!pwm_q && !$past(pwm_q) |-> pwm_out == '0)
    else $error("pwm output high outside pwm mode");
endmodule

// >>> testbench.sv
// testbench: register driven checks of the pwm timer
module testbench
  import mpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [NUM_CAP-1:0] cap_in;
  logic [NUM_PWM:1]   pwm_out;
  int                 num_errors, n_checks, rises;
  int                 cyc = 0;
  int                 hi [1:NUM_PWM];
  int                 mv [7] = '{9, 3, 0, 2, 7, 8, 1};  // period 10, edges
  int                 ex [1:NUM_PWM] = '{12, 0, 0, 15, 0, 9}; // high cycles per 30
  mpt_pwm_timer mpt_pwm_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq));
  // free running clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer, only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd       = prdata;
    last_err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // high cycles per output and rises of output 1
  task automatic measure(input int n);
    logic p1;
    foreach (hi[k]) hi[k] = 0;
    rises = 0;
    p1 = pwm_out[1];
    repeat (n) begin
      @(posedge pclk);
      foreach (hi[k]) hi[k] += int'(pwm_out[k] === 1'b1);
      rises += int'(pwm_out[1] === 1'b1 && p1 === 1'b0);
      p1 = pwm_out[1];
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cap_in = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 'h40; a += 4) rdc("reset value", 8'(a), 32'h0);
    apb(1'b1, 8'h44, 32'hFFFF_FFFF);
    chk("unmapped write error", 32'h1, {31'h0, last_err});
    rdc("unmapped read data", 8'h80, 32'h0);
    chk("unmapped read error", 32'h1, {31'h0, last_err});
    apb(1'b1, OFF_PRECOUNT, 32'h5);
    rdc("precount read only", OFF_PRECOUNT, 32'h0);
    // prescaled run to match 0 with interrupt, reset and stop
    apb(1'b1, OFF_PRESCALE, 32'h2);
    apb(1'b1, OFF_MATCH0, 32'h5);
    apb(1'b1, OFF_MATCHCTL, 32'h7);
    apb(1'b1, OFF_MASK, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    idle(8);
    rdc("status early", OFF_STATUS, 32'h0);
    idle(15);
    rdc("status late", OFF_STATUS, 32'h1);
    chk("irq set", 32'h1, {31'h0, irq});
    rdc("count reset", OFF_COUNT, 32'h0);
    rdc("run stopped", OFF_CTRL, 32'h0);
    rdc("precount restart", OFF_PRECOUNT, 32'h0);
    apb(1'b1, OFF_MASK, 32'h0);
    idle(1);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_MASK, 32'h1);
    idle(1);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_STATUS, 32'h1);
    idle(1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("status cleared", OFF_STATUS, 32'h0);
    // plain timer wraps at 32 bits, hold forces zero
    apb(1'b1, OFF_MATCHCTL, 32'h0);
    apb(1'b1, OFF_PRESCALE, 32'h0);
    apb(1'b1, OFF_COUNT, 32'hFFFF_FFFE);
    apb(1'b1, OFF_CTRL, 32'h1);
    idle(4);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("count wrapped", 32'h1, {31'h0, rd < 32'h10 && rd > 32'h0});
    apb(1'b1, OFF_CTRL, 32'h3);
    rdc("count held", OFF_COUNT, 32'h0);
    // capture input edges as count source, every edge mode
    for (int m = 1; m <= 3; m++) begin
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, OFF_COUNT, 32'h0);
      apb(1'b1, OFF_CNTCTL, 32'(m) | 32'h4);
      apb(1'b1, OFF_CTRL, 32'h1);
      // input 0 toggles twice as fast, so a wrong select miscounts
      repeat (4) begin
        cap_in <= 2'b11;
        idle(1);
        cap_in <= 2'b10;
        idle(1);
        cap_in <= 2'b01;
        idle(1);
        cap_in <= 2'b00;
        idle(1);
      end
      rdc("capture count", OFF_COUNT, (m == 3) ? 32'h8 : 32'h4);
    end
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_CNTCTL, 32'h0);
    // pwm: out1 single, out2 constant low, out4 positive, out6 negative pulse
    foreach (mv[k]) apb(1'b1, OFF_MATCH0 + 8'(4 * k), 32'(mv[k]));
    apb(1'b1, OFF_PWMCTL, 32'h5650);
    apb(1'b1, OFF_RELEASE, 32'h7F);
    apb(1'b1, OFF_CTRL, 32'h5);
    idle(25);
    measure(30);
    foreach (ex[k]) chk("pwm high cycles", 32'(ex[k]), 32'(hi[k]));
    chk("pwm rises", 32'h3, 32'(rises));
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("count below period", 32'h1, {31'h0, rd < 32'hA});
    apb(1'b1, OFF_MATCH0 + 8'h4, 32'h5);
    idle(20);
    measure(30);
    chk("unreleased edge", 32'd12, 32'(hi[1]));
    apb(1'b1, OFF_RELEASE, 32'h2);
    idle(25);
    measure(30);
    chk("released edge", 32'd18, 32'(hi[1]));
    rdc("release consumed", OFF_RELEASE, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h1);
    idle(2);
    chk("pwm off outputs", 32'h0, 32'(pwm_out));
    wrap_up();
  end
endmodule
bind mpt_pwm_timer mpt_pwm_chk mpt_pwm_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
  .pwm_out(pwm_out), .irq(irq));
